// *** hw/iosd_cfg.svh ***
// offsets, bit layouts, reset value and address windows of the io space decoder
`ifndef IOSD_CFG_SVH
`define IOSD_CFG_SVH

// ==========================================
// address windows
`define IOSD_IO_ADDR_W 6
`define IOSD_IO_LOCATIONS 64
`define IOSD_DATA_IO_BASE 8'h20
`define IOSD_EXT_IO_BASE 8'h60
`define IOSD_BIT_OP_TOP 6'h1f
`define IOSD_RESET_VALUE 8'h00

// ==========================================
// io offsets (data address is offset plus base)
`define IOSD_OFS_PORT_B_PIN_LEVELS 6'h03
`define IOSD_OFS_PORT_B_DIRECTION 6'h04
`define IOSD_OFS_PORT_B_OUTPUT_LATCH 6'h05
`define IOSD_OFS_PORT_C_PIN_LEVELS 6'h06
`define IOSD_OFS_PORT_C_DIRECTION 6'h07
`define IOSD_OFS_PORT_C_OUTPUT_LATCH 6'h08
`define IOSD_OFS_PORT_D_PIN_LEVELS 6'h09
`define IOSD_OFS_PORT_D_DIRECTION 6'h0a
`define IOSD_OFS_PORT_D_OUTPUT_LATCH 6'h0b
`define IOSD_OFS_PORT_E_PIN_LEVELS 6'h0c
`define IOSD_OFS_PORT_E_DIRECTION 6'h0d
`define IOSD_OFS_PORT_E_OUTPUT_LATCH 6'h0e
`define IOSD_OFS_TIMER8_EVENT_FLAGS 6'h15
`define IOSD_OFS_TIMER16_EVENT_FLAGS 6'h16
`define IOSD_OFS_SCRATCH_BYTE_ONE 6'h19
`define IOSD_OFS_SCRATCH_BYTE_TWO 6'h1a
`define IOSD_OFS_SCRATCH_BYTE_THREE 6'h1b
`define IOSD_OFS_EXTERNAL_IRQ_FLAGS 6'h1c
`define IOSD_OFS_EXTERNAL_IRQ_MASK 6'h1d
`define IOSD_OFS_SCRATCH_BYTE_ZERO 6'h1e
`define IOSD_OFS_NVM_DATA_CONTROL 6'h1f
`define IOSD_OFS_NVM_DATA_BYTE 6'h20
`define IOSD_OFS_NVM_ADDRESS_LOW 6'h21
`define IOSD_OFS_NVM_ADDRESS_HIGH 6'h22
`define IOSD_OFS_TIMER_GLOBAL_CONTROL 6'h23
`define IOSD_OFS_TIMER8_CONTROL_A 6'h24
`define IOSD_OFS_TIMER8_CONTROL_B 6'h25
`define IOSD_OFS_TIMER8_COUNT 6'h26
`define IOSD_OFS_TIMER8_COMPARE_A 6'h27
`define IOSD_OFS_TIMER8_COMPARE_B 6'h28
`define IOSD_OFS_PLL_CONTROL_STATUS 6'h29
`define IOSD_OFS_SERIAL_PERIPH_CONTROL 6'h2c

// ==========================================
// bit layouts: writable, write-one-to-clear, hardware-loaded, strobe
`define IOSD_M_FULL 8'hff
`define IOSD_M_PORT_E 8'h07
`define IOSD_M_TIMER8_FLAGS 8'h07
`define IOSD_M_TIMER16_FLAGS 8'h27
`define IOSD_M_EXT_IRQ 8'h0f
`define IOSD_M_NVM_CONTROL 8'h0f
`define IOSD_M_NVM_ADDR_HIGH 8'h0f
`define IOSD_M_TIMER_GLOBAL 8'hc1
`define IOSD_M_TIMER8_CTL_A 8'hf3
`define IOSD_M_TIMER8_CTL_B 8'h0f
`define IOSD_M_TIMER8_FORCE 8'hc0
`define IOSD_M_PLL_WRITE 8'h06
`define IOSD_M_PLL_LOCK 8'h01

`endif

// *** hw/iosd_pkg.sv ***
// types and the per-location bit layout of the io space decoder
`include "iosd_cfg.svh"

package iosd_pkg;

    // ==========================================
    // core access kinds
    typedef enum logic [2:0] {
        IOSD_IO_IN = 3'h0,
        IOSD_IO_OUT = 3'h1,
        IOSD_SET_SINGLE_BIT_OP = 3'h2,
        IOSD_CLEAR_SINGLE_BIT_OP = 3'h3,
        IOSD_SKIP_IF_BIT_SET_OP = 3'h4,
        IOSD_SKIP_IF_BIT_CLEAR_OP = 3'h5,
        IOSD_DATA_LOAD_OP = 3'h6,
        IOSD_DATA_STORE_OP = 3'h7
    } iosd_op_e;

    typedef struct packed {
        logic valid;
        iosd_op_e op;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } iosd_req_s;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic skip;
        logic refused;
    } iosd_rsp_s;

    typedef struct packed {
        logic [7:0] pin_b;
        logic [7:0] pin_c;
        logic [7:0] pin_d;
        logic [7:0] pin_e;
        logic [7:0] timer8_events;
        logic [7:0] timer16_events;
        logic [7:0] ext_irq_events;
        logic pll_locked;
    } iosd_hw_s;

    typedef struct packed {
        logic [7:0] dir_b;
        logic [7:0] latch_b;
        logic [7:0] dir_c;
        logic [7:0] latch_c;
        logic [7:0] dir_d;
        logic [7:0] latch_d;
        logic [7:0] dir_e;
        logic [7:0] latch_e;
        logic [7:0] timer8_flags;
        logic [7:0] timer16_flags;
        logic [7:0] ext_irq_flags;
        logic [7:0] ext_irq_mask;
        logic [7:0] nvm_control;
        logic [7:0] nvm_data;
        logic [7:0] nvm_addr_low;
        logic [7:0] nvm_addr_high;
        logic [7:0] timer_global;
        logic [7:0] timer8_ctl_a;
        logic [7:0] timer8_ctl_b;
        logic [7:0] timer8_count;
        logic [7:0] timer8_cmp_a;
        logic [7:0] timer8_cmp_b;
        logic [7:0] pll_control;
        logic [7:0] spi_control;
    } iosd_ctrl_s;

    typedef struct packed {
        logic [7:0] wr;
        logic [7:0] w1c;
        logic [7:0] hw;
        logic [7:0] strb;
    } iosd_mask_s;

    // all-zero layout marks a reserved location
    function automatic iosd_mask_s iosd_layout(input logic [5:0] idx);
        iosd_mask_s m;
        m = '0;
        case (idx)
            `IOSD_OFS_PORT_B_PIN_LEVELS, `IOSD_OFS_PORT_C_PIN_LEVELS,
            `IOSD_OFS_PORT_D_PIN_LEVELS: m.hw = `IOSD_M_FULL;
            `IOSD_OFS_PORT_E_PIN_LEVELS: m.hw = `IOSD_M_PORT_E;
            `IOSD_OFS_PORT_E_DIRECTION, `IOSD_OFS_PORT_E_OUTPUT_LATCH: m.wr = `IOSD_M_PORT_E;
            `IOSD_OFS_PORT_B_DIRECTION, `IOSD_OFS_PORT_B_OUTPUT_LATCH,
            `IOSD_OFS_PORT_C_DIRECTION, `IOSD_OFS_PORT_C_OUTPUT_LATCH,
            `IOSD_OFS_PORT_D_DIRECTION, `IOSD_OFS_PORT_D_OUTPUT_LATCH,
            `IOSD_OFS_SCRATCH_BYTE_ZERO, `IOSD_OFS_SCRATCH_BYTE_ONE,
            `IOSD_OFS_SCRATCH_BYTE_TWO, `IOSD_OFS_SCRATCH_BYTE_THREE,
            `IOSD_OFS_NVM_DATA_BYTE, `IOSD_OFS_NVM_ADDRESS_LOW,
            `IOSD_OFS_TIMER8_COUNT, `IOSD_OFS_TIMER8_COMPARE_A,
            `IOSD_OFS_TIMER8_COMPARE_B, `IOSD_OFS_SERIAL_PERIPH_CONTROL: m.wr = `IOSD_M_FULL;
            `IOSD_OFS_TIMER8_EVENT_FLAGS: m.w1c = `IOSD_M_TIMER8_FLAGS;
            `IOSD_OFS_TIMER16_EVENT_FLAGS: m.w1c = `IOSD_M_TIMER16_FLAGS;
            `IOSD_OFS_EXTERNAL_IRQ_FLAGS: m.w1c = `IOSD_M_EXT_IRQ;
            `IOSD_OFS_EXTERNAL_IRQ_MASK: m.wr = `IOSD_M_EXT_IRQ;
            `IOSD_OFS_NVM_DATA_CONTROL: m.wr = `IOSD_M_NVM_CONTROL;
            `IOSD_OFS_NVM_ADDRESS_HIGH: m.wr = `IOSD_M_NVM_ADDR_HIGH;
            `IOSD_OFS_TIMER_GLOBAL_CONTROL: m.wr = `IOSD_M_TIMER_GLOBAL;
            `IOSD_OFS_TIMER8_CONTROL_A: m.wr = `IOSD_M_TIMER8_CTL_A;
            `IOSD_OFS_TIMER8_CONTROL_B: begin
                m.wr = `IOSD_M_TIMER8_CTL_B;
                m.strb = `IOSD_M_TIMER8_FORCE;
            end
            `IOSD_OFS_PLL_CONTROL_STATUS: begin
                m.wr = `IOSD_M_PLL_WRITE;
                m.hw = `IOSD_M_PLL_LOCK;
            end
            default: m = '0;
        endcase
        return m;
    endfunction : iosd_layout

endpackage : iosd_pkg

// *** hw/iosd_io_cell.sv ***
// one byte-wide io location with per-bit write, clear, load and strobe behaviour
`timescale 1ns/1ps
`default_nettype none
`include "iosd_cfg.svh"

module iosd_io_cell #(
    parameter logic [7:0] WR_M = 8'h00,
    parameter logic [7:0] W1C_M = 8'h00,
    parameter logic [7:0] HW_M = 8'h00,
    parameter logic [7:0] STRB_M = 8'h00
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // write side
    input wire logic wr,
    input wire logic [7:0] wr_bits,
    input wire logic [7:0] wdata,
    // hardware side
    input wire logic [7:0] hw_set,
    input wire logic [7:0] hw_val,
    // stored value
    output var logic [7:0] q
);

    logic [7:0] next_q;
    logic [7:0] hit;

    always_comb begin
        hit = wr ? wr_bits : 8'h00;
        // only enabled bits move, so a one-bit write leaves its neighbours alone
        next_q = ((q & ~hit) | (wdata & hit)) & WR_M;
        next_q = next_q | (wdata & hit & STRB_M);
        // set wins over a clear in the same cycle
        next_q = next_q | (((q & ~(hit & wdata)) | hw_set) & W1C_M);
        next_q = next_q | (hw_val & HW_M);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= `IOSD_RESET_VALUE;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

endmodule : iosd_io_cell

`default_nettype wire

// *** hw/iosd_decoder.sv ***
// io space decoder: maps core io and data accesses onto the low io register bank
//
// Notes on behaviour
// - bit set and clear only below 0x20
// - bit test and skip only below 0x20
// - status flags clear on written one
// - bit operations touch only the addressed bit
// - io instructions use six-bit addresses 0x00-0x3f
// - data address equals io address plus 0x20
// - extended range reached by data accesses only
`timescale 1ns/1ps
`default_nettype none
`include "iosd_cfg.svh"

module iosd_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // core access
    input wire iosd_pkg::iosd_req_s req,
    output var iosd_pkg::iosd_rsp_s rsp,
    // pins and peripheral events
    input wire iosd_pkg::iosd_hw_s hw,
    // register image towards the peripherals
    output var iosd_pkg::iosd_ctrl_s ctrl
);
    import iosd_pkg::*;

    // ==========================================
    // decode
    logic [7:0] q_a [`IOSD_IO_LOCATIONS];
    logic [7:0] hw_set_a [`IOSD_IO_LOCATIONS];
    logic [7:0] hw_val_a [`IOSD_IO_LOCATIONS];
    logic [`IOSD_IO_LOCATIONS-1:0] wr_a;
    logic io_op;
    logic bit_op;
    logic is_write;
    logic is_read;
    logic bit_ok;
    logic in_io;
    logic in_ext;
    logic mapped;
    logic [5:0] idx;
    logic [7:0] data_off;
    logic [7:0] onehot;
    logic [7:0] wr_bits;
    logic [7:0] wr_data;
    logic [7:0] rd_byte;
    logic sel_bit;
    iosd_rsp_s next_rsp;

    always_comb begin
        io_op = (req.op != IOSD_DATA_LOAD_OP) && (req.op != IOSD_DATA_STORE_OP);
        bit_op = (req.op == IOSD_SET_SINGLE_BIT_OP) || (req.op == IOSD_CLEAR_SINGLE_BIT_OP)
            || (req.op == IOSD_SKIP_IF_BIT_SET_OP) || (req.op == IOSD_SKIP_IF_BIT_CLEAR_OP);
        is_read = (req.op == IOSD_IO_IN) || (req.op == IOSD_DATA_LOAD_OP);
        is_write = (req.op == IOSD_IO_OUT) || (req.op == IOSD_DATA_STORE_OP)
            || (req.op == IOSD_SET_SINGLE_BIT_OP) || (req.op == IOSD_CLEAR_SINGLE_BIT_OP);
        data_off = req.addr - `IOSD_DATA_IO_BASE;
        // io opcodes carry six address bits
        // data window sits 0x20 above io
        idx = io_op ? req.addr[5:0] : data_off[5:0];
        in_ext = !io_op && (req.addr >= `IOSD_EXT_IO_BASE);
        in_io = io_op || ((req.addr >= `IOSD_DATA_IO_BASE) && !in_ext);
        mapped = in_io && (iosd_layout(idx) != '0);
        // bit access limited to low 32 locations
        bit_ok = (idx <= `IOSD_BIT_OP_TOP);
        onehot = 8'h01 << req.bit_sel;
        // bit ops enable one bit lane only
        wr_bits = (bit_op ? onehot : 8'hff);
        wr_data = req.wdata;
        if (req.op == IOSD_SET_SINGLE_BIT_OP) begin
            wr_data = 8'hff;
        end else if (req.op == IOSD_CLEAR_SINGLE_BIT_OP) begin
            wr_data = 8'h00;
        end
        rd_byte = mapped ? q_a[idx] : 8'h00;
        sel_bit = rd_byte[req.bit_sel];
    end

    // ==========================================
    // write strobes per location
    always_comb begin
        wr_a = '0;
        // reserved writes dropped, never reach a cell
        // extended range decodes outside this bank
        if (req.valid && is_write && mapped && (!bit_op || bit_ok)) begin
            wr_a[idx] = 1'b1;
        end
    end

    // ==========================================
    // hardware inputs per location
    always_comb begin
        for (int i = 0; i < `IOSD_IO_LOCATIONS; i++) begin
            hw_set_a[i] = 8'h00;
            hw_val_a[i] = 8'h00;
        end
        hw_val_a[`IOSD_OFS_PORT_B_PIN_LEVELS] = hw.pin_b;
        hw_val_a[`IOSD_OFS_PORT_C_PIN_LEVELS] = hw.pin_c;
        hw_val_a[`IOSD_OFS_PORT_D_PIN_LEVELS] = hw.pin_d;
        hw_val_a[`IOSD_OFS_PORT_E_PIN_LEVELS] = hw.pin_e;
        hw_val_a[`IOSD_OFS_PLL_CONTROL_STATUS] = {7'h00, hw.pll_locked};
        hw_set_a[`IOSD_OFS_TIMER8_EVENT_FLAGS] = hw.timer8_events;
        hw_set_a[`IOSD_OFS_TIMER16_EVENT_FLAGS] = hw.timer16_events;
        hw_set_a[`IOSD_OFS_EXTERNAL_IRQ_FLAGS] = hw.ext_irq_events;
    end

    // ==========================================
    // register bank
    // unmapped cells have all-zero layouts and reduce to constant zero
    for (genvar g = 0; g < `IOSD_IO_LOCATIONS; g++) begin : g_loc
        localparam iosd_mask_s M = iosd_layout(6'(g));
        // flag lanes clear on a written one
        iosd_io_cell #(
            .WR_M(M.wr),
            .W1C_M(M.w1c),
            .HW_M(M.hw),
            .STRB_M(M.strb)
        ) u_cell (
            .clk(clk),
            .arst_n(arst_n),
            .clk_en(clk_en),
            .wr(wr_a[g]),
            .wr_bits(wr_bits),
            .wdata(wr_data),
            .hw_set(hw_set_a[g]),
            .hw_val(hw_val_a[g]),
            .q(q_a[g])
        );
    end

    // ==========================================
    // answer to the core
    always_comb begin
        next_rsp = '0;
        next_rsp.ack = req.valid;
        if (req.valid) begin
            next_rsp.rdata = is_read ? rd_byte : 8'h00;
            // skip decision from the addressed bit
            if (bit_ok && (req.op == IOSD_SKIP_IF_BIT_SET_OP)) begin
                next_rsp.skip = sel_bit;
            end else if (bit_ok && (req.op == IOSD_SKIP_IF_BIT_CLEAR_OP)) begin
                next_rsp.skip = !sel_bit;
            end
            // flag refused bit ops and reserved writes
            next_rsp.refused = (bit_op && !bit_ok) || (is_write && in_io && !mapped)
                || (!io_op && !in_io && !in_ext);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp <= '0;
        end else if (clk_en) begin
            rsp <= next_rsp;
        end
    end

    // ==========================================
    // register image
    assign ctrl = '{
        dir_b: q_a[`IOSD_OFS_PORT_B_DIRECTION],
        latch_b: q_a[`IOSD_OFS_PORT_B_OUTPUT_LATCH],
        dir_c: q_a[`IOSD_OFS_PORT_C_DIRECTION],
        latch_c: q_a[`IOSD_OFS_PORT_C_OUTPUT_LATCH],
        dir_d: q_a[`IOSD_OFS_PORT_D_DIRECTION],
        latch_d: q_a[`IOSD_OFS_PORT_D_OUTPUT_LATCH],
        dir_e: q_a[`IOSD_OFS_PORT_E_DIRECTION],
        latch_e: q_a[`IOSD_OFS_PORT_E_OUTPUT_LATCH],
        timer8_flags: q_a[`IOSD_OFS_TIMER8_EVENT_FLAGS],
        timer16_flags: q_a[`IOSD_OFS_TIMER16_EVENT_FLAGS],
        ext_irq_flags: q_a[`IOSD_OFS_EXTERNAL_IRQ_FLAGS],
        ext_irq_mask: q_a[`IOSD_OFS_EXTERNAL_IRQ_MASK],
        nvm_control: q_a[`IOSD_OFS_NVM_DATA_CONTROL],
        nvm_data: q_a[`IOSD_OFS_NVM_DATA_BYTE],
        nvm_addr_low: q_a[`IOSD_OFS_NVM_ADDRESS_LOW],
        nvm_addr_high: q_a[`IOSD_OFS_NVM_ADDRESS_HIGH],
        timer_global: q_a[`IOSD_OFS_TIMER_GLOBAL_CONTROL],
        timer8_ctl_a: q_a[`IOSD_OFS_TIMER8_CONTROL_A],
        timer8_ctl_b: q_a[`IOSD_OFS_TIMER8_CONTROL_B],
        timer8_count: q_a[`IOSD_OFS_TIMER8_COUNT],
        timer8_cmp_a: q_a[`IOSD_OFS_TIMER8_COMPARE_A],
        timer8_cmp_b: q_a[`IOSD_OFS_TIMER8_COMPARE_B],
        pll_control: q_a[`IOSD_OFS_PLL_CONTROL_STATUS],
        spi_control: q_a[`IOSD_OFS_SERIAL_PERIPH_CONTROL]
    };

    // ==========================================
    // checks
    logic [7:0] io_byte;
    logic [7:0] alias_byte;
    logic [7:0] eif_keep;
    logic eif_hit;
    logic t8_clr0;
    logic t8_set_and_clr0;
    logic force_live;
    logic t8_keep0;

    always_comb begin
        io_byte = q_a[req.addr[5:0]];
        alias_byte = q_a[data_off[5:0]];
        eif_keep = q_a[`IOSD_OFS_EXTERNAL_IRQ_FLAGS] & ~onehot;
        eif_hit = req.valid && (idx == `IOSD_OFS_EXTERNAL_IRQ_FLAGS) && io_op
            && ((req.op == IOSD_SET_SINGLE_BIT_OP) || (req.op == IOSD_CLEAR_SINGLE_BIT_OP));
        t8_clr0 = req.valid && (req.op == IOSD_IO_OUT) && req.wdata[0]
            && (req.addr[5:0] == `IOSD_OFS_TIMER8_EVENT_FLAGS);
        t8_set_and_clr0 = t8_clr0 && hw.timer8_events[0];
        force_live = q_a[`IOSD_OFS_TIMER8_CONTROL_B][7] && !wr_a[`IOSD_OFS_TIMER8_CONTROL_B];
        t8_keep0 = req.valid && (req.op == IOSD_IO_OUT) && !req.wdata[0]
            && (req.addr[5:0] == `IOSD_OFS_TIMER8_EVENT_FLAGS);
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_bitop_range: assert property (
        clk_en && req.valid && bit_op && !bit_ok |=> rsp.refused && !rsp.skip)
        else $error("bit operation above 0x1f not refused");

    a_bit_set_lane: assert property (
        clk_en && req.valid && (req.op == IOSD_SET_SINGLE_BIT_OP)
        && (req.addr[5:0] == `IOSD_OFS_PORT_B_OUTPUT_LATCH)
        |=> q_a[`IOSD_OFS_PORT_B_OUTPUT_LATCH][$past(req.bit_sel)])
        else $error("bit set did not reach the latch");

    a_skip_decision: assert property (
        clk_en && req.valid && bit_ok && (req.op == IOSD_SKIP_IF_BIT_SET_OP)
        |=> rsp.ack && (rsp.skip == $past(sel_bit)))
        else $error("skip does not follow tested bit");

    a_flag_w1c: assert property (
        clk_en && t8_clr0 && !hw.timer8_events[0]
        |=> !q_a[`IOSD_OFS_TIMER8_EVENT_FLAGS][0])
        else $error("flag not cleared by written one");

    a_flag_set_wins: assert property (
        clk_en && t8_set_and_clr0 |=> q_a[`IOSD_OFS_TIMER8_EVENT_FLAGS][0])
        else $error("event lost against clear");

    a_bitop_neighbours: assert property (
        clk_en && eif_hit |=> ($past(eif_keep) & ~q_a[`IOSD_OFS_EXTERNAL_IRQ_FLAGS]) == 8'h00)
        else $error("bit operation disturbed neighbour flags");

    a_io_read_path: assert property (
        clk_en && req.valid && (req.op == IOSD_IO_IN) && !force_live
        |=> rsp.rdata == $past(io_byte))
        else $error("io read returned wrong byte");

    a_data_alias: assert property (
        clk_en && req.valid && (req.op == IOSD_DATA_LOAD_OP) && in_io
        |=> rsp.rdata == $past(alias_byte))
        else $error("data load not offset by 0x20");

    a_ext_window: assert property (
        clk_en && req.valid && in_ext |=> !rsp.refused && (rsp.rdata == 8'h00) ##1 1'b1)
        else $error("extended range answered from io bank");

    a_reserved_quiet: assert property (
        clk_en && req.valid && (req.op == IOSD_IO_OUT) && !mapped
        |=> rsp.refused && (q_a[$past(req.addr[5:0])] == 8'h00))
        else $error("reserved write not refused");

    a_force_pulse: assert property (
        clk_en && force_live |=> !q_a[`IOSD_OFS_TIMER8_CONTROL_B][7])
        else $error("force strobe stayed high");

    a_flag_zero_keeps: assert property (
        clk_en && t8_keep0 && q_a[`IOSD_OFS_TIMER8_EVENT_FLAGS][0]
        |=> q_a[`IOSD_OFS_TIMER8_EVENT_FLAGS][0])
        else $error("written zero cleared a flag");

    a_io_write_path: assert property (
        clk_en && req.valid && (req.op == IOSD_IO_OUT)
        && (req.addr[5:0] == `IOSD_OFS_PORT_B_OUTPUT_LATCH)
        |=> ctrl.latch_b == $past(req.wdata))
        else $error("io write missed the latch");

    a_data_store_alias: assert property (
        clk_en && req.valid && (req.op == IOSD_DATA_STORE_OP)
        && (req.addr == ({2'h0, `IOSD_OFS_PORT_B_DIRECTION} + `IOSD_DATA_IO_BASE))
        |=> ctrl.dir_b == $past(req.wdata))
        else $error("data store missed its io location");

    // enable low must hold the register image and the answer
    a_enable_freeze: assert property (
        !clk_en |=> $stable(ctrl) && $stable(rsp))
        else $error("state moved while enable low");

    c_set_wins: cover property (clk_en && t8_set_and_clr0);
    c_skip_taken: cover property (clk_en && req.valid && bit_ok && (req.op == IOSD_SKIP_IF_BIT_CLEAR_OP) ##1 rsp.skip);
    c_flag_clear: cover property (clk_en && eif_hit && (req.op == IOSD_SET_SINGLE_BIT_OP));
    c_data_store: cover property (clk_en && req.valid && (req.op == IOSD_DATA_STORE_OP) && mapped);
    c_refused: cover property (clk_en && req.valid ##1 rsp.refused);

endmodule : iosd_decoder

`default_nettype wire

// *** bench/iosd_core_model.sv ***
// processor core model: issues one decoder access at a time
`timescale 1ns/1ps
`default_nettype none

module iosd_core_model (
    // clock
    input wire logic clk,
    // access towards the decoder
    output var iosd_pkg::iosd_req_s req,
    input wire iosd_pkg::iosd_rsp_s rsp
);
    import iosd_pkg::*;

    initial req = '0;

    // ==========================================
    // access sequence
    // io ops carry six address bits
    task automatic access(input iosd_op_e op, input logic [7:0] a, input logic [2:0] b,
                          input logic [7:0] wd, output iosd_rsp_s r);
        @(negedge clk);
        req.valid = 1'b1;
        req.op = op;
        req.addr = (op >= IOSD_DATA_LOAD_OP) ? a : {2'h0, a[5:0]};
        req.bit_sel = b;
        req.wdata = wd;
        @(negedge clk);
        r = rsp;
        // released fields flip so stale values never look valid
        req.valid = 1'b0;
        req.addr = ~req.addr;
        req.wdata = ~req.wdata;
    endtask : access

endmodule : iosd_core_model

`default_nettype wire

// *** bench/test_io_space_register_decoder.sv ***
// self-checking bench of the io space decoder against a register model
`timescale 1ns/1ps
`default_nettype none

module test_io_space_register_decoder;
    import iosd_pkg::*;

    logic clk;
    logic arst_n;
    logic clk_en;
    iosd_req_s req;
    iosd_rsp_s rsp;
    iosd_hw_s hw;
    iosd_ctrl_s ctrl;
    iosd_rsp_s rs;
    int error_cnt;
    int comparisons;
    logic [31:0] seed;
    logic [7:0] mem [64];
    logic [7:0] wm [64];
    logic [7:0] cm [64];
    // io index and writable bits of each plain register
    logic [15:0] rw_tab [25] = '{16'h04ff, 16'h05ff, 16'h07ff, 16'h08ff, 16'h0aff, 16'h0bff,
        16'h0d07, 16'h0e07, 16'h19ff, 16'h1aff, 16'h1bff, 16'h1d0f, 16'h1eff, 16'h1f0f,
        16'h20ff, 16'h21ff, 16'h220f, 16'h23c1, 16'h24f3, 16'h26ff, 16'h27ff, 16'h28ff,
        16'h2cff, 16'h250f, 16'h2906};

    iosd_decoder DUT (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .req(req), .rsp(rsp),
        .hw(hw), .ctrl(ctrl));
    iosd_core_model core (.clk(clk), .req(req), .rsp(rsp));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // one access, its answer compared, then the model updated
    task automatic op(input iosd_op_e o, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] d, input logic refuse);
        logic [5:0] i;
        logic [7:0] bm;
        logic [7:0] nv;
        logic ext;
        i = (o >= IOSD_DATA_LOAD_OP) ? 6'(a - 8'h20) : a[5:0];
        ext = (o >= IOSD_DATA_LOAD_OP) && (a >= 8'h60);
        bm = 8'h01 << b;
        core.access(o, a, b, d, rs);
        check("ack refused", {6'h00, rs.ack, rs.refused}, {6'h00, 1'b1, refuse});
        if (o == IOSD_IO_IN || o == IOSD_DATA_LOAD_OP)
            check("rdata", rs.rdata, (refuse || ext) ? 8'h00 : mem[i]);
        if ((o == IOSD_SKIP_IF_BIT_SET_OP || o == IOSD_SKIP_IF_BIT_CLEAR_OP) && !refuse)
            check("skip", {7'h00, rs.skip},
                {7'h00, mem[i][b] ^ (o == IOSD_SKIP_IF_BIT_CLEAR_OP)});
        if (!refuse && !ext && (o inside {IOSD_IO_OUT, IOSD_SET_SINGLE_BIT_OP,
                IOSD_CLEAR_SINGLE_BIT_OP, IOSD_DATA_STORE_OP})) begin
            nv = (o == IOSD_SET_SINGLE_BIT_OP) ? (mem[i] | bm) :
                (o == IOSD_CLEAR_SINGLE_BIT_OP) ? (mem[i] & ~bm) : d;
            mem[i] = (mem[i] & ~wm[i]) | (nv & wm[i]);
            // a written one clears only its own flag
            mem[i] = mem[i] & ~(cm[i] & ((o == IOSD_SET_SINGLE_BIT_OP) ? bm :
                (o == IOSD_CLEAR_SINGLE_BIT_OP) ? 8'h00 : d));
        end
    endtask : op

    // ==========================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    // ==========================================
    // main sequence
    initial begin
        logic [7:0] d;
        logic [5:0] a;
        error_cnt = 0;
        comparisons = 0;
        seed = 32'h4eeb52cc;
        clk_en = 1'b1;
        arst_n = 1'b0;
        hw = '0;
        mem = '{default: 8'h00};
        wm = '{default: 8'h00};
        cm = '{default: 8'h00};
        foreach (rw_tab[k]) wm[rw_tab[k][13:8]] = rw_tab[k][7:0];
        cm[6'h15] = 8'h07;
        cm[6'h16] = 8'h27;
        cm[6'h1c] = 8'h0f;
        hw.pin_b = seed[7:0];
        hw.pin_e = seed[15:8];
        hw.pll_locked = 1'b1;
        mem[6'h03] = hw.pin_b;
        mem[6'h0c] = hw.pin_e & 8'h07;
        mem[6'h29] = 8'h01;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        // whole io space after reset, reserved places read zero
        for (int k = 0; k < 64; k++) op(IOSD_IO_IN, 8'(k), 3'h0, 8'h00, 1'b0);
        // random bytes, reserved bits zero, crossing both paths
        foreach (rw_tab[k]) begin
            seed = lfsr(seed);
            a = rw_tab[k][13:8];
            d = seed[7:0] & rw_tab[k][7:0];
            op(k[0] ? IOSD_IO_OUT : IOSD_DATA_STORE_OP,
                {2'h0, a} + (k[0] ? 8'h00 : 8'h20), 3'h0, d, 1'b0);
            op(k[0] ? IOSD_DATA_LOAD_OP : IOSD_IO_IN,
                {2'h0, a} + (k[0] ? 8'h20 : 8'h00), 3'h0, 8'h00, 1'b0);
        end
        check("ctrl latch", ctrl.latch_b, mem[6'h05]);
        check("ctrl dir", ctrl.dir_e, mem[6'h0d]);
        // hardware sets flags, a written one clears
        @(negedge clk);
        hw.ext_irq_events = 8'h0f;
        hw.timer16_events = 8'h27;
        @(negedge clk);
        hw.ext_irq_events = 8'h00;
        hw.timer16_events = 8'h00;
        mem[6'h1c] = 8'h0f;
        mem[6'h16] = 8'h27;
        op(IOSD_IO_OUT, 8'h16, 3'h0, 8'h21, 1'b0);
        op(IOSD_DATA_LOAD_OP, 8'h36, 3'h0, 8'h00, 1'b0);
        // single-bit ops on flags and on two plain bytes
        op(IOSD_SET_SINGLE_BIT_OP, 8'h1c, 3'h2, 8'h00, 1'b0);
        op(IOSD_CLEAR_SINGLE_BIT_OP, 8'h1c, 3'h0, 8'h00, 1'b0);
        op(IOSD_SET_SINGLE_BIT_OP, 8'h1e, 3'h5, 8'h00, 1'b0);
        op(IOSD_CLEAR_SINGLE_BIT_OP, 8'h1e, 3'h0, 8'h00, 1'b0);
        op(IOSD_SET_SINGLE_BIT_OP, 8'h05, 3'h6, 8'h00, 1'b0);
        check("ctrl bits", ctrl.latch_b, mem[6'h05]);
        op(IOSD_IO_IN, 8'h1c, 3'h0, 8'h00, 1'b0);
        op(IOSD_IO_IN, 8'h1e, 3'h0, 8'h00, 1'b0);
        // both skip polarities on each flag
        for (int k = 0; k < 4; k++) begin
            op(IOSD_SKIP_IF_BIT_SET_OP, 8'h1c, 3'(k), 8'h00, 1'b0);
            op(IOSD_SKIP_IF_BIT_CLEAR_OP, 8'h1c, 3'(k), 8'h00, 1'b0);
        end
        // enable low freezes, then an event beats a same-cycle clear
        clk_en = 1'b0;
        hw.timer8_events = 8'h07;
        @(negedge clk);
        clk_en = 1'b1;
        hw.timer8_events = 8'h01;
        check("frozen flags", ctrl.timer8_flags, mem[6'h15]);
        op(IOSD_IO_OUT, 8'h15, 3'h0, 8'h01, 1'b0);
        hw.timer8_events = 8'h00;
        mem[6'h15] = 8'h01;
        check("set wins", ctrl.timer8_flags, mem[6'h15]);
        op(IOSD_IO_OUT, 8'h15, 3'h0, 8'h06, 1'b0);
        op(IOSD_IO_OUT, 8'h15, 3'h0, 8'h01, 1'b0);
        op(IOSD_IO_IN, 8'h15, 3'h0, 8'h00, 1'b0);
        // force strobes read one for a single cycle only
        op(IOSD_IO_OUT, 8'h25, 3'h0, mem[6'h25] | 8'hc0, 1'b0);
        check("force", ctrl.timer8_ctl_b, mem[6'h25] | 8'hc0);
        op(IOSD_IO_IN, 8'h25, 3'h0, 8'h00, 1'b0);
        // refused accesses and the extended window
        op(IOSD_IO_OUT, 8'h10, 3'h0, 8'h5a, 1'b1);
        op(IOSD_IO_IN, 8'h10, 3'h0, 8'h00, 1'b0);
        op(IOSD_SET_SINGLE_BIT_OP, 8'h23, 3'h1, 8'h00, 1'b1);
        op(IOSD_SKIP_IF_BIT_SET_OP, 8'h23, 3'h0, 8'h00, 1'b1);
        op(IOSD_IO_IN, 8'h23, 3'h0, 8'h00, 1'b0);
        op(IOSD_DATA_LOAD_OP, 8'h10, 3'h0, 8'h00, 1'b1);
        op(IOSD_DATA_STORE_OP, 8'h70, 3'h0, 8'h33, 1'b0);
        op(IOSD_DATA_LOAD_OP, 8'h70, 3'h0, 8'h00, 1'b0);
        end_sim();
    end

endmodule : test_io_space_register_decoder

`default_nettype wire
